// ===== shared/pfc_defines.svh
// pfc_defines.svh: constant macros for the feedback combiner
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH

// ****************************************************************
// register map (word indices, byte address is index times four)
// ****************************************************************
`define PFC_ADDR_W 4
`define PFC_OFS_CTRL 4'h0
`define PFC_OFS_SETPT1 4'h1
`define PFC_OFS_SETPT2 4'h2
`define PFC_OFS_REMREF 4'h3
`define PFC_OFS_BUSFB1 4'h4
`define PFC_OFS_BUSFB2 4'h5
`define PFC_OFS_FB_OUT 4'h6
`define PFC_OFS_REF_OUT 4'h7
`define PFC_OFS_ERR_OUT 4'h8
`define PFC_OFS_STATUS 4'h9

// ****************************************************************
// control field positions and reset values
// ****************************************************************
`define PFC_CTRL_COMB_LSB 0
`define PFC_CTRL_COMB_MSB 3
`define PFC_CTRL_SHAPE_BIT 4
`define PFC_CTRL_DIR_BIT 5
`define PFC_CTRL_CLOSED_BIT 6
`define PFC_COMB_RESET 4'h1
`define PFC_SETPT_RESET 32'h0000_0000
`define PFC_UNMAPPED_READ 32'h0000_0000

`endif

// ===== shared/pfc_pkg.sv
// pfc_pkg.sv: types shared by the feedback combiner
package pfc_pkg;

   typedef enum logic [3:0] {
      PFC_COMB_MIN,
      PFC_COMB_MAX,
      PFC_COMB_SUM,
      PFC_COMB_DIFF,
      PFC_COMB_AVG,
      PFC_COMB_ZONE_LARGER,
      PFC_COMB_ZONE_SMALLER,
      PFC_COMB_FB1_ONLY,
      PFC_COMB_FB2_ONLY
   } pfc_combine_t;

   typedef enum logic {
      PFC_SHAPE_LINEAR,
      PFC_SHAPE_SQRT
   } pfc_shape_t;

   typedef enum logic {
      PFC_DIR_NORMAL,
      PFC_DIR_INVERSE
   } pfc_dir_t;

   // signed process values from the two analog transmitters
   typedef struct packed {
      logic signed [31:0] analog1;
      logic signed [31:0] analog2;
   } pfc_analog_t;

   typedef struct packed {
      logic signed [31:0] feedback;
      logic signed [31:0] reference;
      logic signed [31:0] error;
      logic zone2;
      logic valid;
   } pfc_result_t;

endpackage : pfc_pkg

// ===== verilog/pfc_combiner.sv
// pfc_combiner.sv: feedback forming, combining and setpoint selection ahead of the pid
// Operation
// - feedback 1 is bus feedback 1 plus analog input one
// - feedback 2 is bus feedback 2 plus analog input two
// - shape select 0 passes feedback, 1 takes its square root
// - feedback path runs in open and closed loop alike
// - single setpoint: reference is remote reference plus setpoint one, setpoint two in code 8
// - combine code 0 uses the lower feedback
// - combine code 1, the default, uses the higher feedback
// - code 2 sums both feedbacks, reference uses setpoint one
// - code 3 uses feedback two minus feedback one
// - code 4 averages both feedbacks, reference uses setpoint one
// - code 5 picks zone with larger signed setpoint minus feedback
// - larger-difference mode adds winning zone setpoint to remote reference
// - code 6 picks zone with smaller signed setpoint minus feedback
// - smaller-difference mode adds setpoint two if zone two wins
// - code 7 uses analog one only, paired with setpoint one
// - code 8 uses analog two only, paired with setpoint two
// - setpoint one resets to zero and is the closed loop reference
// - setpoint two used in code 8, and only closed loop in two-zone modes
// - direction setting: normal 0 default, inverse 1
// - normal lowers output as feedback rises, inverse raises it
`include "pfc_defines.svh"

module pfc_combiner
   import pfc_pkg::*;
#(
   parameter int VAL_W = 32
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rstn_in,
   // avalon-mm slave
   input wire logic [`PFC_ADDR_W+1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // analog transmitter values
   input wire pfc_analog_t analog_in,
   // regulator side
   output pfc_result_t result_out
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [3:0] comb;
      pfc_shape_t shape;
      pfc_dir_t dir;
      logic closed;
      logic signed [31:0] setpt1;
      logic signed [31:0] setpt2;
      logic signed [31:0] remref;
      logic signed [31:0] busfb1;
      logic signed [31:0] busfb2;
      logic signed [31:0] fb1;
      logic signed [31:0] fb2;
      logic [4:0] sq_cnt;
      logic [31:0] sq_rem;
      logic [15:0] sq_root;
      logic [31:0] sq_src;
      logic sq_sel;
      logic signed [31:0] sh1;
      logic signed [31:0] sh2;
      logic ack;
      logic [31:0] rdata;
      pfc_result_t res;
   } pfc_state_t;

   pfc_state_t s_reg;
   pfc_state_t s_next;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction : merge_be

   logic signed [32:0] sum1;
   logic signed [32:0] sum2;
   logic signed [32:0] fsum;
   logic signed [32:0] fdiff;
   logic signed [32:0] d1;
   logic signed [32:0] d2;
   logic signed [32:0] ref_sum;
   logic signed [32:0] err;
   logic signed [31:0] fb_sel;
   logic signed [31:0] sp_sel;
   logic zone2;
   logic [31:0] sq_cand;
   logic [3:0] wa;

   always_comb begin
      s_next = s_reg;
      wa = avs_address_in[`PFC_ADDR_W+1:2];
      // one wait cycle per access: waitrequest is low only in the answer cycle
      s_next.ack = (avs_read_in || avs_write_in) && !s_reg.ack;
      // a write lands at the edge where the master sees waitrequest low
      if (avs_write_in && s_reg.ack) begin
         unique case (wa)
            `PFC_OFS_CTRL: begin
               if (avs_byteenable_in[0]) begin
                  s_next.comb = avs_writedata_in[`PFC_CTRL_COMB_MSB:`PFC_CTRL_COMB_LSB];
                  s_next.shape = pfc_shape_t'(avs_writedata_in[`PFC_CTRL_SHAPE_BIT]);
                  s_next.dir = pfc_dir_t'(avs_writedata_in[`PFC_CTRL_DIR_BIT]);
                  s_next.closed = avs_writedata_in[`PFC_CTRL_CLOSED_BIT];
               end
            end
            `PFC_OFS_SETPT1: begin
               s_next.setpt1 = merge_be(s_reg.setpt1, avs_writedata_in, avs_byteenable_in);
            end
            `PFC_OFS_SETPT2: begin
               s_next.setpt2 = merge_be(s_reg.setpt2, avs_writedata_in, avs_byteenable_in);
            end
            `PFC_OFS_REMREF: begin
               s_next.remref = merge_be(s_reg.remref, avs_writedata_in, avs_byteenable_in);
            end
            `PFC_OFS_BUSFB1: begin
               s_next.busfb1 = merge_be(s_reg.busfb1, avs_writedata_in, avs_byteenable_in);
            end
            `PFC_OFS_BUSFB2: begin
               s_next.busfb2 = merge_be(s_reg.busfb2, avs_writedata_in, avs_byteenable_in);
            end
            default: begin
            end
         endcase
      end
      unique case (wa)
         `PFC_OFS_CTRL: begin
            s_next.rdata = {25'h0, s_reg.closed, s_reg.dir, s_reg.shape, s_reg.comb};
         end
         `PFC_OFS_SETPT1: begin
            s_next.rdata = s_reg.setpt1;
         end
         `PFC_OFS_SETPT2: begin
            s_next.rdata = s_reg.setpt2;
         end
         `PFC_OFS_REMREF: begin
            s_next.rdata = s_reg.remref;
         end
         `PFC_OFS_BUSFB1: begin
            s_next.rdata = s_reg.busfb1;
         end
         `PFC_OFS_BUSFB2: begin
            s_next.rdata = s_reg.busfb2;
         end
         `PFC_OFS_FB_OUT: begin
            s_next.rdata = s_reg.res.feedback;
         end
         `PFC_OFS_REF_OUT: begin
            s_next.rdata = s_reg.res.reference;
         end
         `PFC_OFS_ERR_OUT: begin
            s_next.rdata = s_reg.res.error;
         end
         `PFC_OFS_STATUS: begin
            s_next.rdata = {30'h0, s_reg.res.zone2, s_reg.res.valid};
         end
         default: begin
            s_next.rdata = `PFC_UNMAPPED_READ;
         end
      endcase

      // ****************************************************************
      // feedback forming, runs regardless of loop mode
      // ****************************************************************
      sum1 = 33'(s_reg.busfb1) + 33'(analog_in.analog1);
      sum2 = 33'(s_reg.busfb2) + 33'(analog_in.analog2);
      // saturate to keep the signed range of process units
      if (sum1 > 33'sh0_7fff_ffff) begin
         s_next.fb1 = 32'sh7fff_ffff;
      end else if (sum1 < -33'sh0_8000_0000) begin
         s_next.fb1 = 32'sh8000_0000;
      end else begin
         s_next.fb1 = sum1[31:0];
      end
      if (sum2 > 33'sh0_7fff_ffff) begin
         s_next.fb2 = 32'sh7fff_ffff;
      end else if (sum2 < -33'sh0_8000_0000) begin
         s_next.fb2 = 32'sh8000_0000;
      end else begin
         s_next.fb2 = sum2[31:0];
      end

      // serial square root, one bit per cycle, alternating between the two feedbacks;
      // trades latency (17 cycles per value, 34 per feedback) for one small datapath
      sq_cand = 32'({s_reg.sq_root, 2'b01}) << (2 * s_reg.sq_cnt[3:0]);
      if (s_reg.sq_cnt == 5'h10) begin
         if (s_reg.sq_sel) begin
            s_next.sh2 = {16'h0, s_reg.sq_root};
         end else begin
            s_next.sh1 = {16'h0, s_reg.sq_root};
         end
         s_next.sq_sel = !s_reg.sq_sel;
         // negative feedback has no real root and is clamped to zero
         if (s_reg.sq_sel) begin
            s_next.sq_src = s_reg.fb1[31] ? 32'h0 : s_reg.fb1;
         end else begin
            s_next.sq_src = s_reg.fb2[31] ? 32'h0 : s_reg.fb2;
         end
         s_next.sq_rem = s_next.sq_src;
         s_next.sq_root = 16'h0;
         s_next.sq_cnt = 5'hf;
      end else begin
         // restoring step: test the bit pair at position sq_cnt
         if (s_reg.sq_rem >= sq_cand) begin
            s_next.sq_rem = s_reg.sq_rem - sq_cand;
            s_next.sq_root = {s_reg.sq_root[14:0], 1'b1};
         end else begin
            s_next.sq_root = {s_reg.sq_root[14:0], 1'b0};
         end
         if (s_reg.sq_cnt == 5'h0) begin
            s_next.sq_cnt = 5'h10;
         end else begin
            s_next.sq_cnt = s_reg.sq_cnt - 5'h1;
         end
      end
      if (s_reg.shape == PFC_SHAPE_LINEAR) begin
         s_next.sh1 = s_reg.fb1;
         s_next.sh2 = s_reg.fb2;
      end

      // ****************************************************************
      // combining and setpoint selection
      // ****************************************************************
      fsum = 33'(s_reg.sh1) + 33'(s_reg.sh2);
      fdiff = 33'(s_reg.sh2) - 33'(s_reg.sh1);
      d1 = 33'(s_reg.setpt1) - 33'(s_reg.sh1);
      d2 = 33'(s_reg.setpt2) - 33'(s_reg.sh2);
      fb_sel = s_reg.sh1;
      sp_sel = s_reg.setpt1;
      zone2 = 1'b0;
      unique case (s_reg.comb)
         PFC_COMB_MIN: begin
            fb_sel = (s_reg.sh1 < s_reg.sh2) ? s_reg.sh1 : s_reg.sh2;
         end
         PFC_COMB_MAX: begin
            fb_sel = (s_reg.sh1 > s_reg.sh2) ? s_reg.sh1 : s_reg.sh2;
         end
         PFC_COMB_SUM: begin
            // the total wraps to the value width
            fb_sel = fsum[31:0];
         end
         PFC_COMB_DIFF: begin
            fb_sel = fdiff[31:0];
         end
         PFC_COMB_AVG: begin
            fb_sel = fsum[32:1];
         end
         PFC_COMB_ZONE_LARGER: begin
            zone2 = d2 > d1;
         end
         PFC_COMB_ZONE_SMALLER: begin
            zone2 = d2 < d1;
         end
         PFC_COMB_FB1_ONLY: begin
            fb_sel = analog_in.analog1;
         end
         PFC_COMB_FB2_ONLY: begin
            fb_sel = analog_in.analog2;
            sp_sel = s_reg.setpt2;
         end
         default: begin
            fb_sel = s_reg.sh1;
         end
      endcase
      if (s_reg.comb == PFC_COMB_ZONE_LARGER || s_reg.comb == PFC_COMB_ZONE_SMALLER) begin
         fb_sel = zone2 ? s_reg.sh2 : s_reg.sh1;
         // second setpoint only in closed loop
         sp_sel = (zone2 && s_reg.closed) ? s_reg.setpt2 : s_reg.setpt1;
      end
      ref_sum = 33'(s_reg.remref) + 33'(sp_sel);
      s_next.res.feedback = fb_sel;
      s_next.res.reference = ref_sum[31:0];
      // error sign gives frequency direction
      if (s_reg.dir == PFC_DIR_NORMAL) begin
         err = ref_sum - 33'(fb_sel);
      end else begin
         err = 33'(fb_sel) - ref_sum;
      end
      s_next.res.error = err[31:0];
      s_next.res.zone2 = zone2 && s_reg.closed;
      s_next.res.valid = s_reg.closed;
      if (!rstn_in) begin
         s_next = '0;
         s_next.comb = `PFC_COMB_RESET;
         s_next.setpt1 = `PFC_SETPT_RESET;
         s_next.setpt2 = `PFC_SETPT_RESET;
         s_next.sq_cnt = 5'h10;
      end
   end

   always_ff @(posedge mclk_in) begin
      s_reg <= s_next;
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   always_comb begin
      avs_readdata_out = s_reg.rdata;
      avs_waitrequest_out = !s_reg.ack;
      result_out = s_reg.res;
   end

endmodule : pfc_combiner

// ===== test/pfc_combiner_asserts.sv
// pfc_combiner_asserts.sv: port checker for the feedback combiner
`include "pfc_defines.svh"

module pfc_combiner_chk
   import pfc_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic rstn_in,
   // avalon-mm slave
   input wire logic [`PFC_ADDR_W+1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // process side
   input wire pfc_analog_t analog_in,
   input wire pfc_result_t result_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // shadow of direction and closed-loop bits, updated in the answer cycle
   logic [1:0] mode_reg;
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         mode_reg <= 2'h0;
      end else if (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
                   && avs_address_in[5:2] == 4'h0) begin
         // bit 1 holds direction, bit 0 holds closed loop
         mode_reg <= {avs_writedata_in[5], avs_writedata_in[6]};
      end
   end

   default clocking cb @(posedge mclk_in); endclocking

   a_wait_one: assert property (disable iff (!rstn_in)
      (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("request not answered after one wait cycle");
   a_idle_wait: assert property (disable iff (!rstn_in)
      !(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
      else $error("answer without a request");
   a_answer_pulse: assert property (disable iff (!rstn_in)
      !avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("answer longer than one cycle");
   a_unmapped_read: assert property (disable iff (!rstn_in)
      avs_read_in && avs_waitrequest_out && avs_address_in[5:2] > 4'h9
      |=> avs_readdata_out == 32'h0)
      else $error("unmapped read returned nonzero");
   a_reset_clear: assert property (
      !rstn_in |=> avs_waitrequest_out && avs_readdata_out == 32'h0 && result_out == '0)
      else $error("outputs not cleared by reset");
   a_valid_closed: assert property (disable iff (!rstn_in)
      mode_reg[0] [*4] |-> result_out.valid)
      else $error("valid low in closed loop");
   a_valid_open: assert property (disable iff (!rstn_in)
      !mode_reg[0] [*4] |-> !result_out.valid)
      else $error("valid high in open loop");
   a_err_normal: assert property (disable iff (!rstn_in)
      (!mode_reg[1] [*4]) ##0 result_out.valid
      |-> result_out.error == result_out.reference - result_out.feedback)
      else $error("normal error wrong");
   a_err_inverse: assert property (disable iff (!rstn_in)
      (mode_reg[1] [*4]) ##0 result_out.valid
      |-> result_out.error == result_out.feedback - result_out.reference)
      else $error("inverse error wrong");

   c_zone2: cover property (disable iff (!rstn_in) result_out.zone2);
   c_read: cover property (disable iff (!rstn_in) avs_read_in && !avs_waitrequest_out);
   c_write: cover property (disable iff (!rstn_in) avs_write_in && !avs_waitrequest_out);
endmodule : pfc_combiner_chk

bind pfc_combiner pfc_combiner_chk i_pfc_combiner_chk (.mclk_in(mclk_in),
   .rstn_in(rstn_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
   .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .analog_in(analog_in),
   .result_out(result_out));

// ===== test/pfc_xmtr_model.sv
// pfc_xmtr_model.sv: two process transmitters on the analog voltage inputs
module pfc_xmtr_model
   import pfc_pkg::*;
(
   // clock
   input wire logic mclk_in,
   // commanded process levels
   input wire logic signed [31:0] level1_in,
   input wire logic signed [31:0] level2_in,
   // analog inputs of the combiner
   output pfc_analog_t analog_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // both zone feedbacks sit on the two voltage inputs, one per zone
   always_ff @(posedge mclk_in) begin
      analog_out.analog1 <= level1_in;
      analog_out.analog2 <= level2_in;
   end
endmodule : pfc_xmtr_model

// ===== test/tb.sv
// tb.sv: self-checking bench for the feedback combiner
module tb import pfc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [5:0] avs_address_in = 6'h00;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0] avs_byteenable_in = 4'hf;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic signed [31:0] level1 = 32'sh0;
   logic signed [31:0] level2 = 32'sh0;
   pfc_analog_t analog;
   pfc_result_t res;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [31:0] r;
   logic [31:0] efb [9] = '{32'h96, 32'hdc, 32'h172, 32'h46, 32'hb9, 32'h96, 32'hdc,
                           32'h32, 32'hc8};
   logic [31:0] eref [9] = '{32'h514, 32'h514, 32'h514, 32'h514, 32'h514, 32'h514,
                            32'h44c, 32'h514, 32'h44c};

   always #12.5 mclk_in = ~mclk_in;

   pfc_xmtr_model i_pfc_xmtr_model (.mclk_in(mclk_in), .level1_in(level1),
      .level2_in(level2), .analog_out(analog));
   pfc_combiner i_pfc_combiner (.mclk_in(mclk_in), .rstn_in(rstn_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .analog_in(analog), .result_out(res));

   // ****************************************************************
   // bus cycles and comparison
   // ****************************************************************
   task automatic bus_wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_byteenable_in <= be;
      avs_write_in <= 1'b1;
      do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
      avs_write_in <= 1'b0;
      @(posedge mclk_in);
   endtask : bus_wr

   task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
      avs_address_in <= a;
      avs_read_in <= 1'b1;
      do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
      d = avs_readdata_out;
      avs_read_in <= 1'b0;
      @(posedge mclk_in);
   endtask : bus_rd

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic results();
      if (bad_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results

   // a hang costs a mismatch; the whole sequence needs well under this
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         bad_count++;
         results();
      end
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (20) @(posedge mclk_in);
      rstn_in <= 1'b1;
      bus_rd(6'h00, r);
      chk(r, 32'h1);
      bus_rd(6'h04, r);
      chk(r, 32'h0);
      bus_rd(6'h08, r);
      chk(r, 32'h0);
      bus_rd(6'h28, r);
      chk(r, 32'h0);
      level1 <= 32'sh32;
      level2 <= 32'shc8;
      bus_wr(6'h10, 32'h64, 4'hf);
      bus_wr(6'h14, 32'h14, 4'hf);
      bus_wr(6'h04, 32'h12c, 4'hf);
      bus_wr(6'h08, 32'h64, 4'hf);
      bus_wr(6'h0c, 32'h3e8, 4'hf);
      // every combine code in closed loop, linear shape
      for (int i = 0; i < 9; i++) begin
         bus_wr(6'h00, 32'h40 | i, 4'hf);
         repeat (6) @(posedge mclk_in);
         chk(res.feedback, efb[i]);
         chk(res.reference, eref[i]);
         chk(res.error, eref[i] - efb[i]);
         if (i == 5 || i == 6) begin
            chk({31'h0, res.zone2}, {31'h0, i == 6});
         end
         bus_rd(6'h18, r);
         chk(r, efb[i]);
      end
      // control lane 0 disabled: write must leave control as it was
      bus_wr(6'h00, 32'h0, 4'he);
      bus_rd(6'h00, r);
      chk(r, 32'h48);
      // square root with a plain minimum, never with a zone function; then linear inverse closed loop and open loop
      bus_wr(6'h10, 32'h5e, 4'hf);
      bus_wr(6'h00, 32'h50, 4'hf);
      repeat (100) @(posedge mclk_in);
      chk(res.feedback, 32'hc);
      bus_wr(6'h00, 32'h60, 4'hf);
      repeat (6) @(posedge mclk_in);
      chk(res.feedback, 32'h90);
      chk(res.error, 32'h90 - 32'h514);
      bus_wr(6'h00, 32'h00, 4'hf);
      repeat (6) @(posedge mclk_in);
      chk({31'h0, res.valid}, 32'h0);
      chk(res.feedback, 32'h90);
      bus_rd(6'h24, r);
      chk(r, 32'h0);
      results();
   end
endmodule : tb
